// ===== logic/swst_top.sv
// Notes on behaviour
// - drain word at 21b0, bits 6..0 used
// - status bit 1 closed, 0 open
// - positive word at 21b4, reserved 11,9,31:15
// - negative word at 21b8, reserved 7,31:12
// - tia word at 21bc, bits 11,9,8
// - all read-only, reset to zero
// - tia bits 6..0 used, bit 7 reserved
`timescale 1ns/1ps
`default_nettype none
`include "swst_defs.svh"

// ****************************************
// switch status bank, axi4-lite slave
// ****************************************
module swst_top
    import swst_pkg::*;
#(
    parameter int ADDR_W = 16
)
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // live switch states from the control registers
    input wire logic [31:0] drain_state,
    input wire logic [31:0] pos_state,
    input wire logic [31:0] neg_state,
    input wire logic [31:0] tia_state,
    // write address channel
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address channel
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ****************************************
    // address decode
    // ****************************************
    function automatic swst_sel_e decode(input logic [ADDR_W-1:0] a);
        logic [15:0] w;
        w = 16'(a);
        // upper bits must be zero as well for a hit
        if (a != ADDR_W'(w))
            return SWST_SEL_NONE;
        case ({w[15:2], 2'b00})
            `SWST_DRAIN_OFS: return SWST_SEL_DRAIN;
            `SWST_POS_OFS: return SWST_SEL_POS;
            `SWST_NEG_OFS: return SWST_SEL_NEG;
            `SWST_TIA_OFS: return SWST_SEL_TIA;
            default: return SWST_SEL_NONE;
        endcase
    endfunction : decode

    // ****************************************
    // status capture
    // ****************************************
    swst_if stat ();

    swst_capture u_capture (
        .clock(clock),
        .sys_rst(sys_rst),
        .drain_state(drain_state),
        .pos_state(pos_state),
        .neg_state(neg_state),
        .tia_state(tia_state),
        .stat(stat)
    );

    // ****************************************
    // write path: accepted, never stored
    // ****************************************
    logic aw_got; // address held, waiting data
    logic w_got; // data held, waiting address
    logic aw_hit; // held address was mapped
    logic next_aw_got;
    logic next_w_got;
    logic next_aw_hit;
    logic next_awready;
    logic next_wready;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic aw_take; // address handshake now
    logic w_take; // data handshake now
    logic have_aw; // address known this cycle
    logic have_w; // data known this cycle
    logic hit_now; // mapped address this cycle
    logic fire; // response launched

    // next state of the write side
    always_comb
    begin
        aw_take = s_axi_awvalid & s_axi_awready;
        w_take = s_axi_wvalid & s_axi_wready;
        have_aw = aw_got | aw_take;
        have_w = w_got | w_take;
        hit_now = aw_take ? (decode(s_axi_awaddr) != SWST_SEL_NONE)
                          : aw_hit;
        fire = have_aw & have_w & ~s_axi_bvalid;
        next_aw_hit = hit_now;
        next_aw_got = have_aw & ~fire;
        next_w_got = have_w & ~fire;
        next_bresp = s_axi_bresp;
        if (s_axi_bvalid)
        begin
            // hold until the master takes it
            next_bvalid = ~s_axi_bready;
        end
        else
        begin
            next_bvalid = fire;
        end
        if (fire)
        begin
            // data is dropped: the words are read-only
            next_bresp = hit_now ? `SWST_RESP_OKAY
                                 : `SWST_RESP_DECERR;
        end
        // one write at a time: stop taking while busy
        next_awready = ~next_aw_got & ~next_bvalid;
        next_wready = ~next_w_got & ~next_bvalid;
    end

    // write side registers
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_hit <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SWST_RESP_OKAY;
        end
        else
        begin
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            aw_hit <= next_aw_hit;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
        end
    end

    // ****************************************
    // read path
    // ****************************************
    logic next_arready;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic ar_take; // read address handshake now

    // next state of the read side
    always_comb
    begin
        ar_take = s_axi_arvalid & s_axi_arready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_rvalid)
        begin
            // data stands until rready
            next_rvalid = ~s_axi_rready;
        end
        else
        begin
            next_rvalid = ar_take;
        end
        if (ar_take)
        begin
            next_rresp = `SWST_RESP_OKAY;
            case (decode(s_axi_araddr))
                SWST_SEL_DRAIN: next_rdata = stat.drain;
                SWST_SEL_POS: next_rdata = stat.pos;
                SWST_SEL_NEG: next_rdata = stat.neg;
                SWST_SEL_TIA: next_rdata = stat.tia;
                default:
                begin
                    // unmapped: zero data, decode error
                    next_rdata = 32'h00000000;
                    next_rresp = `SWST_RESP_DECERR;
                end
            endcase
        end
        // one read at a time
        next_arready = ~next_rvalid;
    end

    // read side registers
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `SWST_RESET_VAL;
            s_axi_rresp <= `SWST_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

endmodule : swst_top

`default_nettype wire

// ===== logic/swst_defs.svh
`ifndef SWST_DEFS_SVH
`define SWST_DEFS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define SWST_DRAIN_OFS 16'h21b0
`define SWST_POS_OFS 16'h21b4
`define SWST_NEG_OFS 16'h21b8
`define SWST_TIA_OFS 16'h21bc

// ****************************************
// implemented bit masks (reserved bits 0)
// ****************************************
`define SWST_DRAIN_MASK 32'h0000007f
`define SWST_POS_MASK 32'h000075ff
`define SWST_NEG_MASK 32'h00000f7f
`define SWST_TIA_MASK 32'h00000b7f

// ****************************************
// named field positions
// ****************************************
`define SWST_DRAIN_RETURN_BIT 0
`define SWST_DRAIN_SEVEN_BIT 6
`define SWST_POS_RETURN_BIT 0
`define SWST_POS_LOAD_BIT 13
`define SWST_POS_LOAD_B_BIT 14
`define SWST_NEG_RETURN_BIT 9
`define SWST_NEG_LOAD_BIT 10
`define SWST_NEG_LOAD_B_BIT 11
`define SWST_TIA_SEVEN_BIT 6
`define SWST_TIA_NINE_BIT 8
`define SWST_TIA_TEN_BIT 9
`define SWST_TIA_RETURN_BIT 11

// ****************************************
// reset value and bus answers
// ****************************************
`define SWST_RESET_VAL 32'h00000000
`define SWST_RESP_OKAY 2'h0
`define SWST_RESP_DECERR 2'h3

`endif

// ===== logic/swst_pkg.sv
// ****************************************
// shared types
// ****************************************
package swst_pkg;

    // one 32-bit status word
    typedef logic [31:0] swst_word_t;

    // which status register an address selects
    typedef enum logic [2:0]
    {
        SWST_SEL_DRAIN,
        SWST_SEL_POS,
        SWST_SEL_NEG,
        SWST_SEL_TIA,
        SWST_SEL_NONE
    } swst_sel_e;

endpackage : swst_pkg

// ===== logic/swst_if.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// status words from capture to bus slave
// ****************************************
interface swst_if;
    import swst_pkg::*;

    swst_word_t drain; // drain group word
    swst_word_t pos; // positive group word
    swst_word_t neg; // negative group word
    swst_word_t tia; // tia group word

    // capture side drives, slave side reads
    modport capture (output drain, pos, neg, tia);
    modport reader (input drain, pos, neg, tia);

endinterface : swst_if

`default_nettype wire

// ===== logic/swst_capture.sv
`timescale 1ns/1ps
`default_nettype none
`include "swst_defs.svh"

// ****************************************
// status capture of switch states
// ****************************************
module swst_capture
    import swst_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // live switch states, 1 = closed
    input wire logic [31:0] drain_state,
    input wire logic [31:0] pos_state,
    input wire logic [31:0] neg_state,
    input wire logic [31:0] tia_state,
    // captured words
    swst_if.capture stat
);

    swst_word_t word [4]; // registered words
    swst_word_t next_word [4]; // next values
    swst_word_t raw [4]; // unmasked inputs
    swst_word_t mask [4]; // implemented bits

    // ****************************************
    // next value: masked copy of live state
    // ****************************************
    always_comb
    begin
        raw[0] = drain_state;
        raw[1] = pos_state;
        raw[2] = neg_state;
        raw[3] = tia_state;
        mask[0] = `SWST_DRAIN_MASK;
        mask[1] = `SWST_POS_MASK;
        mask[2] = `SWST_NEG_MASK;
        mask[3] = `SWST_TIA_MASK;
        for (int i = 0; i < 4; i++)
        begin
            // closed reads 1, open reads 0, reserved forced low
            next_word[i] = raw[i] & mask[i];
        end
    end

    // ****************************************
    // registers, cleared by reset
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_word
            always_ff @(posedge clock)
            begin
                if (sys_rst)
                    word[g] <= `SWST_RESET_VAL;
                else
                    word[g] <= next_word[g];
            end
        end
    endgenerate

    // hand words to the slave
    assign stat.drain = word[0];
    assign stat.pos = word[1];
    assign stat.neg = word[2];
    assign stat.tia = word[3];

endmodule : swst_capture

`default_nettype wire

// ===== verif/swst_asserts.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// bus and readback checker
// ****************************************
module swst_asserts
    import swst_pkg::*;
#(
    parameter int ADDR_W = 16
)
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // watched switch states
    input wire logic [31:0] drain_state,
    // write side
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    // read side
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [ADDR_W-1:0] ra; // address of the read in flight
    logic [ADDR_W-1:0] next_ra; // next value of ra
    logic hit; // read hits the four-word bank
    logic ar_go; // read address taken this cycle

    // remember the taken read address until the answer
    always_comb
    begin
        ar_go = s_axi_arvalid && s_axi_arready;
        next_ra = ar_go ? s_axi_araddr : ra;
        hit = ra[ADDR_W-1:4] == (ADDR_W-4)'(12'h21b);
    end

    always_ff @(posedge clock)
    begin
        ra <= next_ra;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    AST_DRAIN_RSV: assert property (s_axi_rvalid && hit && ra[3:2] == 2'h0
        |-> (s_axi_rdata & ~32'h0000007f) == 32'h0) else $error("drain rsv");
    AST_POS_RSV: assert property (s_axi_rvalid && hit && ra[3:2] == 2'h1
        |-> (s_axi_rdata & ~32'h000075ff) == 32'h0) else $error("pos rsv");
    AST_NEG_RSV: assert property (s_axi_rvalid && hit && ra[3:2] == 2'h2
        |-> (s_axi_rdata & ~32'h00000f7f) == 32'h0) else $error("neg rsv");
    AST_TIA_RSV: assert property (s_axi_rvalid && hit && ra[3:2] == 2'h3
        |-> (s_axi_rdata & ~32'h00000b7f) == 32'h0) else $error("tia rsv");
    // a steady drain input must come back, masked to its used bits, one cycle later
    AST_DRAIN_LIVE: assert property (ar_go && $stable(drain_state)
        && s_axi_araddr[ADDR_W-1:2] == (ADDR_W-2)'(14'h086c)
        |=> s_axi_rdata == ($past(drain_state) & 32'h0000007f))
        else $error("drain live");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r hold");
    AST_B_AFTER: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid) else $error("b");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("ar block");
    AST_RESP_OK: assert property (s_axi_rvalid && hit
        |-> s_axi_rresp == 2'h0) else $error("okay");
    AST_RESP_BAD: assert property (s_axi_rvalid && !hit
        |-> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0) else $error("decerr");
endmodule : swst_asserts

bind swst_top swst_asserts #(.ADDR_W(ADDR_W)) i_swst_asserts (.*);

`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// compare, count, report a mismatch at once
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end

// ****************************************
// testbench top
// ****************************************
module tb_top;
    import swst_pkg::*;
    logic clock, sys_rst;
    logic [31:0] st [4]; // live switch states per group
    logic [15:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    int bad_count, n_compared, cyc;
    logic [15:0] ofs [4] = '{16'h21b0, 16'h21b4, 16'h21b8, 16'h21bc};
    // used bits per group; reserved ones must read 0
    logic [31:0] msk [4] = '{32'h7f, 32'h75ff, 32'hf7f, 32'hb7f};
    logic [31:0] d;
    logic [1:0] r;

    swst_top i_swst_top (.*, .drain_state(st[0]), .pos_state(st[1]),
        .neg_state(st[2]), .tia_state(st[3]));

    initial
    begin
        clock = 0;
        forever #4 clock = ~clock;
    end

    // one read; slow holds rready low a while to stall the answer
    task automatic rd(input logic [15:0] a, input bit slow);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= !slow;
        do @(posedge clock); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 0;
        if (slow)
        begin
            repeat (3) @(posedge clock);
            s_axi_rready <= 1;
        end
        do @(posedge clock); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
    endtask : rd

    // one write; address and data offered together
    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        bit ad, wd;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        ad = 0;
        wd = 0;
        while (!(ad && wd))
        begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready === 1'b1)
            begin
                s_axi_awvalid <= 0;
                ad = 1;
            end
            if (s_axi_wvalid && s_axi_wready === 1'b1)
            begin
                s_axi_wvalid <= 0;
                wd = 1;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge clock);
        r = s_axi_bresp;
        s_axi_bready <= 0;
    endtask : wr

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test

    // hang guard, well above the hundred or so cycles needed
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            stop_test();
        end
    end

    initial
    begin
        sys_rst = 1;
        st = '{4{32'h0}};
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awprot, s_axi_arprot} = '0;
        s_axi_wstrb = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        repeat (12) @(posedge clock);
        sys_rst <= 0;
        foreach (ofs[i])
        begin
            rd(ofs[i], 0);
            `CHK(d, 32'h0)
        end
        $display("test reset done");
        foreach (ofs[i])
        begin
            @(posedge clock);
            st[i] <= 32'hffffffff;
            rd(ofs[i], i[0]);
            `CHK(d, msk[i])
            `CHK(r, 2'h0)
            st[i] <= 32'ha5a5a5a5;
            rd(ofs[i] | 16'h3, 0);
            `CHK(d, 32'ha5a5a5a5 & msk[i])
        end
        $display("test follow done");
        foreach (ofs[i])
        begin
            wr(ofs[i], ~st[i]);
            `CHK(r, 2'h0)
            rd(ofs[i], 0);
            `CHK(d, 32'ha5a5a5a5 & msk[i])
        end
        wr(16'h21c0, 32'h1);
        `CHK(r, 2'h3)
        rd(16'h21c0, 0);
        `CHK(r, 2'h3)
        `CHK(d, 32'h0)
        $display("test write done");
        // leave nonzero read data standing, then reset mid-run
        rd(ofs[1], 0);
        `CHK(d, 32'ha5a5a5a5 & msk[1])
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        `CHK(s_axi_rdata, 32'h0)
        `CHK({s_axi_arready, s_axi_awready, s_axi_rvalid}, 3'h0)
        sys_rst <= 1'b0;
        // words refill from the live inputs after release
        rd(ofs[1], 0);
        `CHK(d, 32'ha5a5a5a5 & msk[1])
        $display("test rerun done");
        stop_test();
    end
endmodule : tb_top

`default_nettype wire
